//--- serial_port_consts.svh
// Constants for the serial port flow control block.
// Assumes inclusion by bare name from design files and the testbench.
`ifndef SERIAL_PORT_FLOW_CONTROL_CONSTS_SVH
`define SERIAL_PORT_FLOW_CONTROL_CONSTS_SVH
`define CLK_HZ 100000000
`define PRT_DELAY_S 2
`define PRT_DELAY_CYC (`CLK_HZ * `PRT_DELAY_S)
`define REG_CTRL 12'h000
`define REG_PCFG 12'h004
`define REG_STAT 12'h008
`define REG_DATA 12'h00c
`define CTRL_RTS_HOLD 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_LOOP 3
`define CTRL_BUSY 4
`define CTRL_READY 5
`define CTRL_DLYGATE 6
`define PCFG_STOP1 0
`define PCFG_PAR_EN 1
`define PCFG_PAR_ODD 2
`define PCFG_BAUD_LO 4
`define PCFG_BAUD_HI 7
`define STAT_BUSY 0
`define STAT_DELAY 1
`define STAT_PENDING 2
`define STAT_RTS 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define LF_CHAR 8'h0a
`define BAUD_SEL_BITS 4
`endif

//--- serial_port_pkg.sv
// Types for the serial port flow control block.
// Assumes the constants header is compiled alongside.
package serial_port_pkg;
   typedef enum logic [1:0] {
      MODE_BLOCK = 2'h0,
      MODE_FULL = 2'h1,
      MODE_HALF = 2'h3
   } port_mode_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_START = 3'h1,
      TX_DATA = 3'h3,
      TX_PAR = 3'h2,
      TX_STOP = 3'h6
   } tx_state_t;
endpackage

//--- baud_tick_gen.sv
// Baud tick generator from a static rate selection.
// Assumes a 100 MHz clock and a quasi-static selection.
`timescale 1ns/1ns
`include "serial_port_consts.svh"
module baud_tick_gen (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Rate selection and tick
   input wire logic [3:0] baudSel,
   output logic tick
);
   import serial_port_pkg::*;
   typedef struct packed {
      logic [20:0] cnt;
      logic tick;
   } state_t;
   state_t s_q, s_d;

   function automatic logic [20:0] divFor(input logic [3:0] sel);
      logic [31:0] baud;
      baud = 32'd19200;
      case (sel)
         4'h0: baud = 32'd75;
         4'h1: baud = 32'd110;
         4'h2: baud = 32'd150;
         4'h3: baud = 32'd300;
         4'h4: baud = 32'd600;
         4'h5: baud = 32'd1000;
         4'h6: baud = 32'd1200;
         4'h7: baud = 32'd1800;
         4'h8: baud = 32'd2000;
         4'h9: baud = 32'd2400;
         4'ha: baud = 32'd3600;
         4'hb: baud = 32'd4800;
         4'hc: baud = 32'd7200;
         4'hd: baud = 32'd9600;
         default: baud = 32'd19200;
      endcase
      divFor = 21'((`CLK_HZ / baud) - 1);
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt >= divFor(baudSel)) begin
         s_d.cnt = 21'h0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 21'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tick = s_q.tick;

   tickPeriod_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      tick |=> !tick) else $error("baud tick longer than one cycle");
endmodule

//--- printer_delay.sv
// Two second printer delay timer, retriggered at end of line.
// Assumes start is a one-cycle pulse from the printer transmitter.
`timescale 1ns/1ns
`include "serial_port_consts.svh"
module printer_delay #(
   parameter int unsigned DELAY_CYC = `PRT_DELAY_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Control
   input wire logic start,
   output logic active
);
   import serial_port_pkg::*;
   typedef struct packed {
      logic [27:0] cnt;
      logic active;
   } state_t;
   state_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (start) begin
         s_d.cnt = 28'(DELAY_CYC - 1);
         s_d.active = 1'b1;
      end else if (s_q.cnt != 28'h0) begin
         s_d.cnt = s_q.cnt - 28'h1;
      end else begin
         s_d.active = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign active = s_q.active;

   delayStart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      start |=> active) else $error("delay not started");
endmodule

//--- serial_port_flow_control.sv
// Serial port flow control: main port RTS, mode and driver select, printer port, aux pass-through.
// Assumes AXI4-Lite master with one access of each kind outstanding, synchronous pins.
// Functional notes
// - Hold option keeps request-to-send at spacing regardless of transmit activity.
// - Transmission option raises request-to-send only while transmitting.
// - Printer stop, parity enable and sense come from separate settings.
// - Printer baud chosen from static selection, 75 to 19200, independent of main.
// - Busy style: spacing level on printer control input withholds printer data.
// - Ready style: marking level on printer control input withholds printer data.
// - Internal printer delay of two seconds for carriage return or line feed; the code starts it on line feed only.
// - Delay starts each time a line is sent and next line begins.
// - Delay blocks printer output only with busy and delay gating both set.
// - Printer delay state is driven on the printer timeout output.
// - Line receive data is forwarded to the auxiliary port, no options.
// - Main port mode is block, full duplex or half duplex.
// - Main data routed through loop or voltage drivers per selection.
// - Stop setting on selects one stop bit, off selects two.
// - Sense on means odd, off even; parity only when enabled.
// - Low request-to-send means terminal receives and accepts computer data.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "serial_port_consts.svh"
module serial_port_flow_control #(
   parameter int unsigned DELAY_CYC = `PRT_DELAY_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // AXI4-Lite write
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Main port
   input wire logic mainTxActive,
   input wire logic mainTxData,
   output logic mainRxData,
   output logic rtsOut,
   output logic [1:0] mainMode,
   // Line drivers
   output logic voltageSignallingTx,
   input wire logic voltageSignallingRx,
   output logic loopSignallingTx,
   input wire logic loopSignallingRx,
   // Printer and aux ports
   output logic printerTx,
   input wire logic printerCtrl,
   output logic printerTimeout,
   output logic auxTx
);
   import serial_port_pkg::*;

   typedef struct packed {
      logic awTaken;
      logic wTaken;
      logic [11:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic awRdy;
      logic wRdy;
      logic arRdy;
      logic [6:0] ctrl;
      logic [7:0] pcfg;
      logic [7:0] txBuf;
      logic pending;
      tx_state_t txState;
      logic [7:0] shiftReg;
      logic [2:0] bitIdx;
      logic parity;
      logic stopLeft;
      logic endOfLine;
      logic startDelay;
      logic rts;
      logic pTx;
      logic mRx;
      logic vTx;
      logic lTx;
      logic aux;
      logic tmo;
      logic [1:0] mode;
   } state_t;
   state_t s_q, s_d;

   logic baudTick;
   logic delayActive;
   logic inhibit;
   logic lineRx;

   function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      mergeWord = r;
   endfunction

   baud_tick_gen baudGen (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .baudSel(s_q.pcfg[`PCFG_BAUD_HI:`PCFG_BAUD_LO]),
      .tick(baudTick)
   );

   printer_delay #(.DELAY_CYC(DELAY_CYC)) lineDelay (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(s_q.startDelay),
      .active(delayActive)
   );

   // Marking is logic 1, spacing is logic 0 on the control input
   assign inhibit = (s_q.ctrl[`CTRL_BUSY] && !printerCtrl)
      || (s_q.ctrl[`CTRL_READY] && printerCtrl)
      || (s_q.ctrl[`CTRL_BUSY] && s_q.ctrl[`CTRL_DLYGATE] && delayActive);

   // Receive source follows the driver selection
   assign lineRx = s_q.ctrl[`CTRL_LOOP] ? loopSignallingRx : voltageSignallingRx;

   always_comb begin
      logic [31:0] wordNew;
      logic wrFire;
      logic sendDone;
      wordNew = 32'h0;
      wrFire = 1'b0;
      sendDone = 1'b0;
      s_d = s_q;
      // Write channel
      if (s_axi_awvalid && s_q.awRdy) begin
         s_d.awTaken = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wRdy) begin
         s_d.wTaken = 1'b1;
         s_d.wData = s_axi_wdata;
         s_d.wStrb = s_axi_wstrb;
      end
      wrFire = s_q.awTaken && s_q.wTaken;
      if (wrFire) begin
         s_d.awTaken = 1'b0;
         s_d.wTaken = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = `RESP_OKAY;
         case (s_q.awAddr)
            `REG_CTRL: begin
               wordNew = mergeWord({25'h0, s_q.ctrl}, s_q.wData, s_q.wStrb);
               s_d.ctrl = wordNew[6:0];
            end
            `REG_PCFG: begin
               wordNew = mergeWord({24'h0, s_q.pcfg}, s_q.wData, s_q.wStrb);
               s_d.pcfg = wordNew[7:0];
            end
            `REG_DATA: begin
               // Writes while a byte is pending are dropped; poll the pending bit first
               if (!s_q.pending && s_q.wStrb[0]) begin
                  s_d.txBuf = s_q.wData[7:0];
                  s_d.pending = 1'b1;
               end
            end
            `REG_STAT: s_d.bResp = `RESP_OKAY;
            default: s_d.bResp = `RESP_SLVERR;
         endcase
      end
      if (s_q.bValid && s_axi_bready) begin
         s_d.bValid = 1'b0;
      end
      // Read channel
      if (s_axi_arvalid && s_q.arRdy) begin
         s_d.rValid = 1'b1;
         s_d.rResp = `RESP_OKAY;
         case (s_axi_araddr)
            `REG_CTRL: s_d.rData = {25'h0, s_q.ctrl};
            `REG_PCFG: s_d.rData = {24'h0, s_q.pcfg};
            `REG_STAT: s_d.rData = {28'h0, s_q.rts, s_q.pending, delayActive, s_q.txState != TX_IDLE};
            `REG_DATA: s_d.rData = {24'h0, s_q.txBuf};
            default: begin
               s_d.rData = 32'h0;
               s_d.rResp = `RESP_SLVERR;
            end
         endcase
      end
      if (s_q.rValid && s_axi_rready) begin
         s_d.rValid = 1'b0;
      end
      // Printer transmitter
      if (baudTick) begin
         case (s_q.txState)
            TX_IDLE: begin
               if (s_q.pending && !inhibit) begin
                  s_d.shiftReg = s_q.txBuf;
                  s_d.endOfLine = (s_q.txBuf == `LF_CHAR);
                  s_d.pending = 1'b0;
                  s_d.parity = s_q.pcfg[`PCFG_PAR_ODD];
                  s_d.pTx = 1'b0;
                  s_d.txState = TX_START;
               end
            end
            TX_START: begin
               s_d.pTx = s_q.shiftReg[0];
               s_d.parity = s_q.parity ^ s_q.shiftReg[0];
               s_d.shiftReg = {1'b0, s_q.shiftReg[7:1]};
               s_d.bitIdx = 3'h1;
               s_d.txState = TX_DATA;
            end
            TX_DATA: begin
               if (s_q.bitIdx == 3'h0) begin
                  if (s_q.pcfg[`PCFG_PAR_EN]) begin
                     s_d.pTx = s_q.parity;
                     s_d.txState = TX_PAR;
                  end else begin
                     s_d.pTx = 1'b1;
                     s_d.stopLeft = !s_q.pcfg[`PCFG_STOP1];
                     s_d.txState = TX_STOP;
                  end
               end else begin
                  s_d.pTx = s_q.shiftReg[0];
                  s_d.parity = s_q.parity ^ s_q.shiftReg[0];
                  s_d.shiftReg = {1'b0, s_q.shiftReg[7:1]};
                  s_d.bitIdx = s_q.bitIdx + 3'h1;
               end
            end
            TX_PAR: begin
               s_d.pTx = 1'b1;
               s_d.stopLeft = !s_q.pcfg[`PCFG_STOP1];
               s_d.txState = TX_STOP;
            end
            TX_STOP: begin
               if (s_q.stopLeft) begin
                  s_d.stopLeft = 1'b0;
               end else begin
                  sendDone = 1'b1;
                  s_d.txState = TX_IDLE;
               end
            end
            default: s_d.txState = TX_IDLE;
         endcase
      end
      s_d.startDelay = sendDone && s_q.endOfLine;
      // Main port
      s_d.rts = !s_q.ctrl[`CTRL_RTS_HOLD] && mainTxActive;
      case (s_q.ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO])
         2'h1: s_d.mode = MODE_FULL;
         2'h2: s_d.mode = MODE_HALF;
         default: s_d.mode = MODE_BLOCK;
      endcase
      s_d.vTx = s_q.ctrl[`CTRL_LOOP] ? 1'b1 : mainTxData;
      s_d.lTx = s_q.ctrl[`CTRL_LOOP] ? mainTxData : 1'b1;
      s_d.mRx = lineRx;
      s_d.aux = lineRx;
      s_d.tmo = delayActive;
      s_d.awRdy = !s_d.awTaken && !s_d.bValid;
      s_d.wRdy = !s_d.wTaken && !s_d.bValid;
      s_d.arRdy = !s_d.rValid;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.pTx <= 1'b1;
         s_q.vTx <= 1'b1;
         s_q.lTx <= 1'b1;
         s_q.mRx <= 1'b1;
         s_q.aux <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = s_q.awRdy;
   assign s_axi_wready = s_q.wRdy;
   assign s_axi_bvalid = s_q.bValid;
   assign s_axi_bresp = s_q.bResp;
   assign s_axi_arready = s_q.arRdy;
   assign s_axi_rvalid = s_q.rValid;
   assign s_axi_rdata = s_q.rData;
   assign s_axi_rresp = s_q.rResp;
   assign rtsOut = s_q.rts;
   assign mainMode = s_q.mode;
   assign voltageSignallingTx = s_q.vTx;
   assign loopSignallingTx = s_q.lTx;
   assign mainRxData = s_q.mRx;
   assign printerTx = s_q.pTx;
   assign printerTimeout = s_q.tmo;
   assign auxTx = s_q.aux;

   sequence startBit_s;
      s_q.txState == TX_IDLE && baudTick && s_q.pending && !inhibit;
   endsequence

   rtsHold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_q.ctrl[`CTRL_RTS_HOLD] |=> !rtsOut) else $error("rts left spacing under hold");
   rtsFollow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !s_q.ctrl[`CTRL_RTS_HOLD] |=> rtsOut == $past(mainTxActive)) else $error("rts not following tx");
   busyInhibit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_q.ctrl[`CTRL_BUSY] && !printerCtrl && s_q.txState == TX_IDLE |=> s_q.txState == TX_IDLE)
      else $error("sent while busy");
   readyInhibit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_q.ctrl[`CTRL_READY] && printerCtrl && s_q.txState == TX_IDLE |=> s_q.txState == TX_IDLE)
      else $error("sent while not ready");
   delayGate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_q.ctrl[`CTRL_BUSY] && s_q.ctrl[`CTRL_DLYGATE] && delayActive && s_q.txState == TX_IDLE
      |=> s_q.txState == TX_IDLE) else $error("sent during delay");
   timeoutOut_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 printerTimeout == $past(delayActive)) else $error("timeout output mismatch");
   auxFwd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ##1 auxTx == $past(lineRx)) else $error("aux not forwarding");
   startBitLow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      startBit_s |=> !printerTx && s_q.txState == TX_START) else $error("no start bit");
   eolDelay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_q.startDelay |=> delayActive) else $error("line delay not started");
   loopRoute_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_q.ctrl[`CTRL_LOOP] |=> loopSignallingTx == $past(mainTxData) && voltageSignallingTx)
      else $error("loop routing wrong");
endmodule

//--- printer_model.sv
// Serial printer on the far side of the printer port: decodes frames, drives the control line.
// Assumes one start bit, eight data bits, one parity bit and one stop bit, LSB first.
`timescale 1ns/1ns
module printer_model #(
   parameter int BIT = 5208
) (
   // Clock
   input wire logic ref_clk,
   // Printer lines
   input wire logic printerTx,
   input wire logic ctlLevel,
   output logic printerCtrl,
   // Decoded frame
   output logic gotByte,
   output logic [9:0] byteVal
);
   logic [9:0] sh;
   // Control line is a steady level the printer holds; marking means idle
   assign printerCtrl = ctlLevel;
   initial begin
      gotByte = 1'b0;
      byteVal = 10'h000;
      forever begin
         @(negedge printerTx);
         // Mid-bit sampling tolerates a small error in the baud divisor
         repeat (BIT / 2) @(posedge ref_clk);
         if (printerTx === 1'b0) begin
            for (int i = 0; i < 10; i++) begin
               repeat (BIT) @(posedge ref_clk);
               sh[i] = printerTx;
            end
            byteVal <= sh;
            gotByte <= 1'b1;
            @(posedge ref_clk);
            gotByte <= 1'b0;
         end
      end
   end
endmodule

//--- serial_port_flow_control_tb.sv
// Self-checking bench for the serial port flow control block.
// Assumes the constants header and printer model are compiled alongside.
`timescale 1ns/1ns
`include "serial_port_consts.svh"
module serial_port_flow_control_tb;
   localparam int DLY = 6000;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] awA = 12'h000, arA = 12'h000;
   logic [31:0] wD = 32'h0, rD;
   logic awV = 0, wV = 0, bR = 0, arV = 0, rR = 0, txAct = 0, txD = 1, vRx = 1, lRx = 1, ctlLvl = 1;
   logic awRdy, wRdy, bV, arRdy, rV, rxD, rts, vTx, lTx, pTx, pCtl, pTo, aux, got;
   logic [1:0] bResp, rResp, mode;
   logic [9:0] pByte;
   logic [31:0] rnd = 32'hbd4f2342;
   logic [33:0] expRd[$];
   logic [9:0] expPr[$];
   logic [1:0] mm[4] = '{2'h0, 2'h1, 2'h3, 2'h0};
   int num_errors = 0, n_compared = 0, cnt, hi, low;

   always #5 ref_clk = ~ref_clk;

   serial_port_flow_control #(.DELAY_CYC(DLY)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bR),
      .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rResp),
      .s_axi_rvalid(rV), .s_axi_rready(rR), .mainTxActive(txAct), .mainTxData(txD), .mainRxData(rxD),
      .rtsOut(rts), .mainMode(mode), .voltageSignallingTx(vTx), .voltageSignallingRx(vRx),
      .loopSignallingTx(lTx), .loopSignallingRx(lRx), .printerTx(pTx), .printerCtrl(pCtl),
      .printerTimeout(pTo), .auxTx(aux));

   printer_model #(.BIT(5208)) partner (.ref_clk(ref_clk), .printerTx(pTx), .ctlLevel(ctlLvl),
      .printerCtrl(pCtl), .gotByte(got), .byteVal(pByte));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("errors %0d, comparisons %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One access at a time; reads note their expected answer for the monitor
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int t;
      logic x, y, u, z;
      logic [1:0] q;
      @(posedge ref_clk);
      if (wr) begin
         awA <= a;
         wD <= d;
         awV <= 1'b1;
         wV <= 1'b1;
         bR <= 1'b1;
      end else begin
         expRd.push_back({er, d});
         arA <= a;
         arV <= 1'b1;
         rR <= 1'b1;
      end
      t = 0;
      do begin
         @(negedge ref_clk);
         x = awV && awRdy;
         y = wV && wRdy;
         u = arV && arRdy;
         z = (bV && bR) || (rV && rR);
         q = bResp;
         @(posedge ref_clk);
         if (x) awV <= 1'b0;
         if (y) wV <= 1'b0;
         if (u) arV <= 1'b0;
         if (z) begin
            bR <= 1'b0;
            rR <= 1'b0;
         end
         t++;
      end while (!z && t < 200);
      if (!z) num_errors++;
      if (wr) chk(q, er);
   endtask

   task automatic hold(input int n);
      int l;
      l = 0;
      repeat (n) begin
         @(negedge ref_clk);
         if (pTx !== 1'b1) l++;
      end
      chk(l, 0);
   endtask

   always @(posedge ref_clk) begin
      if (rV && rR) chk({rResp, rD}, expRd.pop_front());
      if (got) begin
         chk(pByte, expPr.pop_front());
         chk(pTo, 1'b0);
      end
   end

   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      bus(0, `REG_STAT, 32'h0, `RESP_OKAY);
      bus(0, 12'h010, 32'h0, `RESP_SLVERR);
      bus(1, 12'h020, 32'h5, `RESP_SLVERR);
      for (int m = 0; m < 4; m++) begin
         bus(1, `REG_CTRL, m << 1, `RESP_OKAY);
         bus(0, `REG_CTRL, m << 1, `RESP_OKAY);
         @(negedge ref_clk);
         chk(mode, mm[m]);
      end
      @(posedge ref_clk);
      txAct <= 1'b1;
      bus(1, `REG_CTRL, 32'h1, `RESP_OKAY);
      repeat (3) @(negedge ref_clk);
      chk(rts, 1'b0);
      bus(1, `REG_CTRL, 32'h0, `RESP_OKAY);
      bus(0, `REG_STAT, 32'h8, `RESP_OKAY);
      @(posedge ref_clk);
      txAct <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(rts, 1'b0);
      for (int s = 0; s < 2; s++) begin
         bus(1, `REG_CTRL, s << 3, `RESP_OKAY);
         repeat (16) begin
            @(posedge ref_clk);
            rnd = nxt(rnd);
            vRx <= rnd[0];
            lRx <= rnd[1];
            txD <= rnd[2];
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk({rxD, aux, vTx, lTx}, {s ? lRx : vRx, s ? lRx : vRx, s ? 1'b1 : txD, s ? txD : 1'b1});
         end
      end
      // Odd parity, one stop bit, rate 14; LF has two ones so parity bit is 1
      bus(1, `REG_PCFG, 32'he7, `RESP_OKAY);
      bus(1, `REG_CTRL, 32'h20, `RESP_OKAY);
      expPr.push_back(10'h30a);
      bus(1, `REG_DATA, 32'h0a, `RESP_OKAY);
      hold(5400);
      bus(1, `REG_CTRL, 32'h70, `RESP_OKAY);
      @(posedge ref_clk);
      ctlLvl <= 1'b0;
      hold(5400);
      bus(0, `REG_STAT, 32'h4, `RESP_OKAY);
      bus(1, `REG_CTRL, 32'h50, `RESP_OKAY);
      @(posedge ref_clk);
      ctlLvl <= 1'b1;
      cnt = 0;
      while (!got && cnt < 70000) begin
         @(negedge ref_clk);
         cnt++;
      end
      cnt = 0;
      do begin
         @(negedge ref_clk);
         cnt++;
      end while (!pTo && cnt < 6000);
      // Half a bit after mid-stop; two stop bits would take three times longer
      chk(cnt < 2700, 1'b1);
      hi = 1;
      low = 0;
      fork
         bus(1, `REG_DATA, 32'h41, `RESP_OKAY);
         while (pTo && hi < 8000) begin
            @(negedge ref_clk);
            hi += pTo;
            low += !pTx;
         end
      join
      chk(hi, DLY);
      chk(low, 0);
      cnt = 0;
      while (pTx && cnt < 6000) begin
         @(negedge ref_clk);
         cnt++;
      end
      chk(pTx, 1'b0);
      give_verdict();
   end

   initial begin
      #950000;
      num_errors++;
      give_verdict();
   end
endmodule
